/* core/fbl_pkg.sv */
package fbl_pkg;

  // ==========================================================================
  // Flash layout.
  localparam logic [7:0]  SPI_CMD_READ    = 8'h03;
  localparam logic [23:0] LOW_HDR_ADDR    = 24'h000000;
  localparam logic [23:0] HIGH_HDR_ADDR   = 24'h001000;
  localparam logic [23:0] HDR_READ_LEN    = 24'h000008;
  localparam logic [23:0] CSZ_READ_LEN    = 24'h000004;
  localparam logic [31:0] CFG_MAX_BYTES   = 32'h00001000;
  localparam logic [31:0] ALL_ONES        = 32'hffffffff;
  localparam int unsigned FLASH_MIN_BYTES = 1048576;
  localparam int unsigned APP_BYTES_DEF   = 65536;

  // ==========================================================================
  // Timing.
  localparam int unsigned CORE_CLK_HZ   = 20000000;
  localparam int unsigned LINK_CLK_HZ   = 83333333;
  localparam int unsigned SPI_SCK_HZ    = 12000000;
  localparam int unsigned SPI_HALF_CYC  = (LINK_CLK_HZ + 2 * SPI_SCK_HZ - 1) / (2 * SPI_SCK_HZ);
  localparam int unsigned UART_BAUD     = 115200;
  localparam int unsigned UART_BAUD_DIV = CORE_CLK_HZ / UART_BAUD;
  localparam logic [5:0]  SPI_CMD_BITS  = 6'h20;
  localparam logic [5:0]  SPI_BYTE_BITS = 6'h08;
  localparam logic [3:0]  UART_STOP_BIT = 4'h9;

  // ==========================================================================
  // Boot sequencer states.
  typedef enum logic [3:0] {
    S_WAIT_ADDR = 4'b0000,
    S_SUPPLY    = 4'b0001,
    S_DEADBAT   = 4'b0010,
    S_ROLE      = 4'b0011,
    S_HDR       = 4'b0100,
    S_HDR_CHK   = 4'b0101,
    S_CSZ       = 4'b0110,
    S_CSZ_CHK   = 4'b0111,
    S_LOAD      = 4'b1000,
    S_UART      = 4'b1001,
    S_DONE      = 4'b1010,
    S_INVALID   = 4'b1011
  } fbl_state_e;

  typedef enum logic [1:0] {
    L_IDLE = 2'b00,
    L_CMD  = 2'b01,
    L_DATA = 2'b10,
    L_WAIT = 2'b11
  } fbl_link_e;

endpackage

/* core/fbl_spi.sv */
`timescale 1ns/1ns
`default_nettype none
module fbl_spi #(
  parameter int unsigned HALF = fbl_pkg::SPI_HALF_CYC
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        req_tgl_i,
  input  wire logic [23:0] addr_i,
  input  wire logic [23:0] len_i,
  input  wire logic        ack_tgl_i,
  input  wire logic        miso_i,
  output logic             sck_o,
  output logic             cs_n_o,
  output logic             mosi_o,
  output logic [7:0]       byte_o,
  output logic             byte_tgl_o,
  output logic             done_tgl_o
);

  // ==========================================================================
  // Crossings and pin sampling.
  logic [1:0] req_s_q;
  logic [1:0] ack_s_q;
  logic [1:0] miso_s_q;
  logic       req_seen_q;
  logic       ack_seen_q;
  fbl_pkg::fbl_link_e st_q;
  logic [31:0] tx_q;
  logic [7:0]  rx_q;
  logic [5:0]  cnt_q;
  logic [7:0]  div_q;
  logic [23:0] left_q;
  logic        half_w;

  // Only the second flop of each chain is read by logic.
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      req_s_q  <= 2'h0;
      ack_s_q  <= 2'h0;
      miso_s_q <= 2'h0;
    end
    else
    begin
      req_s_q  <= {req_s_q[0], req_tgl_i};
      ack_s_q  <= {ack_s_q[0], ack_tgl_i};
      miso_s_q <= {miso_s_q[0], miso_i};
    end
  end

  assign half_w = (div_q == 8'(HALF - 1));
  assign mosi_o = tx_q[31];
  assign byte_o = rx_q;

  // Mode 0 engine; the clock pauses low between bytes until the core takes each one.
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      st_q <= fbl_pkg::L_IDLE;
      sck_o <= 1'b0;
      cs_n_o <= 1'b1;
      tx_q <= 32'h0;
      rx_q <= 8'h0;
      cnt_q <= 6'h0;
      div_q <= 8'h0;
      left_q <= 24'h0;
      req_seen_q <= 1'b0;
      ack_seen_q <= 1'b0;
      byte_tgl_o <= 1'b0;
      done_tgl_o <= 1'b0;
    end
    else
    begin
      unique case (st_q)
        fbl_pkg::L_IDLE:
        begin
          if (req_s_q[1] != req_seen_q)
          begin
            req_seen_q <= req_s_q[1];
            tx_q <= {fbl_pkg::SPI_CMD_READ, addr_i};
            cs_n_o <= 1'b0;
            cnt_q <= 6'h0;
            div_q <= 8'h0;
            left_q <= len_i;
            st_q <= fbl_pkg::L_CMD;
          end
        end
        fbl_pkg::L_CMD, fbl_pkg::L_DATA:
        begin
          div_q <= half_w ? 8'h0 : div_q + 8'h1;
          if (half_w && !sck_o)
          begin
            sck_o <= 1'b1;
            rx_q <= {rx_q[6:0], miso_s_q[1]};
            cnt_q <= cnt_q + 6'h1;
          end
          else if (half_w)
          begin
            sck_o <= 1'b0;
            tx_q <= {tx_q[30:0], 1'b0};
            if (st_q == fbl_pkg::L_CMD && cnt_q == fbl_pkg::SPI_CMD_BITS)
            begin
              st_q <= fbl_pkg::L_DATA;
              cnt_q <= 6'h0;
            end
            else if (st_q == fbl_pkg::L_DATA && cnt_q == fbl_pkg::SPI_BYTE_BITS)
            begin
              byte_tgl_o <= ~byte_tgl_o;
              left_q <= left_q - 24'h1;
              cnt_q <= 6'h0;
              st_q <= fbl_pkg::L_WAIT;
            end
          end
        end
        fbl_pkg::L_WAIT:
        begin
          if (ack_s_q[1] != ack_seen_q)
          begin
            ack_seen_q <= ack_s_q[1];
            if (left_q == 24'h0)
            begin
              cs_n_o <= 1'b1;
              done_tgl_o <= ~done_tgl_o;
              st_q <= fbl_pkg::L_IDLE;
            end
            else
            begin
              st_q <= fbl_pkg::L_DATA;
            end
          end
        end
      endcase
    end
  end

endmodule // fbl_spi
`default_nettype wire

/* core/fbl_uart_rx.sv */
`timescale 1ns/1ns
`default_nettype none
module fbl_uart_rx #(
  parameter int unsigned DIV = fbl_pkg::UART_BAUD_DIV
) (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       rx_i,
  output logic [7:0]      byte_o,
  output logic            valid_o
);

  // ==========================================================================
  // Receiver.
  logic [1:0]  rx_s_q;
  logic        busy_q;
  logic [15:0] div_q;
  logic [3:0]  bit_q;
  logic [7:0]  sh_q;

  // Line idles high, so the chain resets to one.
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      rx_s_q <= 2'h3;
    else
      rx_s_q <= {rx_s_q[0], rx_i};
  end

  // Samples mid-bit; a start bit gone by mid-bit is taken as noise.
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      busy_q <= 1'b0;
      div_q <= 16'h0;
      bit_q <= 4'h0;
      sh_q <= 8'h0;
      byte_o <= 8'h0;
      valid_o <= 1'b0;
    end
    else
    begin
      valid_o <= 1'b0;
      if (!busy_q)
      begin
        if (!rx_s_q[1])
        begin
          busy_q <= 1'b1;
          div_q <= 16'(DIV / 2);
          bit_q <= 4'h0;
        end
      end
      else if (div_q != 16'h0)
        div_q <= div_q - 16'h1;
      else
      begin
        div_q <= 16'(DIV - 1);
        if (bit_q == 4'h0)
        begin
          busy_q <= ~rx_s_q[1];
          bit_q <= 4'h1;
        end
        else if (bit_q != fbl_pkg::UART_STOP_BIT)
        begin
          sh_q <= {rx_s_q[1], sh_q[7:1]};
          bit_q <= bit_q + 4'h1;
        end
        else
        begin
          busy_q <= 1'b0;
          valid_o <= rx_s_q[1];
          byte_o <= sh_q;
        end
      end
    end
  end

endmodule // fbl_uart_rx
`default_nettype wire

/* core/fbl_top.sv */
`timescale 1ns/1ns
`default_nettype none
module fbl_top #(
  parameter int unsigned FLASH_BYTES = fbl_pkg::FLASH_MIN_BYTES,
  parameter int unsigned APP_BYTES   = fbl_pkg::APP_BYTES_DEF,
  parameter int unsigned SPI_HALF    = fbl_pkg::SPI_HALF_CYC,
  parameter int unsigned BAUD_DIV    = fbl_pkg::UART_BAUD_DIV
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        spi_clk_i,
  input  wire logic        addr_setup_done_i,
  input  wire logic        main_supply_input_i,
  input  wire logic        vbus_valid_i,
  input  wire logic        bus_power_select_pin_i,
  input  wire logic        addr_strap_grounded_i,
  input  wire logic        uart_rx_i,
  input  wire logic        flash_miso_i,
  output logic             flash_sck_o,
  output logic             flash_select_n_o,
  output logic             flash_mosi_o,
  output logic             dead_battery_o,
  output logic             power_path_sel_o,
  output logic             role_secondary_o,
  output logic [7:0]       data_o,
  output logic             data_valid_o,
  output logic             data_is_config_o,
  output logic             boot_done_o,
  output logic             loaded_high_o,
  output logic             both_invalid_o,
  output logic             swd_on_sbu_o
);

  // ==========================================================================
  // Declarations.
  localparam int unsigned NPIN = 5;

  logic [NPIN-1:0] pin_raw_w;
  logic [NPIN-1:0] pin_s1_q;
  logic [NPIN-1:0] pin_s2_q;
  logic            addr_done_w;
  logic            main_ok_w;
  logic            vbus_ok_w;
  logic            bus_pwr_w;
  logic            strap_w;

  fbl_pkg::fbl_state_e st_q;
  logic [63:0] shr_q;
  logic [31:0] csz_q;
  logic [23:0] start_q;
  logic [23:0] rd_addr_q;
  logic [23:0] rd_len_q;
  logic [23:0] cnt_q;
  logic        req_tgl_q;
  logic        ack_tgl_q;
  logic        high_q;

  logic [1:0]  byte_s_q;
  logic [1:0]  done_s_q;
  logic        byte_seen_q;
  logic        done_seen_q;
  logic        new_byte_w;
  logic        new_done_w;

  logic [7:0]  link_byte_w;
  logic        link_byte_tgl_w;
  logic        link_done_tgl_w;
  logic [7:0]  uart_byte_w;
  logic        uart_valid_w;

  logic [31:0] region_base_pointer_w;
  logic [31:0] application_code_offset_w;
  logic [32:0] start_w;
  logic [32:0] end_w;
  logic        hdr_bad_w;
  logic        csz_bad_w;
  logic        bad_w;

  // ==========================================================================
  // Pin synchronisers.
  assign pin_raw_w = {addr_strap_grounded_i, bus_power_select_pin_i, vbus_valid_i,
                      main_supply_input_i, addr_setup_done_i};

  // Each pin passes two flops; nothing reads the first.
  for (genvar i = 0; i < NPIN; i++)
  begin : g_pin_sync
    always_ff @(posedge clk_i or posedge rst_i)
    begin
      if (rst_i)
      begin
        pin_s1_q[i] <= 1'b0;
        pin_s2_q[i] <= 1'b0;
      end
      else
      begin
        pin_s1_q[i] <= pin_raw_w[i];
        pin_s2_q[i] <= pin_s1_q[i];
      end
    end
  end

  assign addr_done_w = pin_s2_q[0];
  assign main_ok_w   = pin_s2_q[1];
  assign vbus_ok_w   = pin_s2_q[2];
  assign bus_pwr_w   = pin_s2_q[3];
  assign strap_w     = pin_s2_q[4];

  // ==========================================================================
  // Link crossing: toggles in, data held stable by the handshake.
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      byte_s_q <= 2'h0;
      done_s_q <= 2'h0;
      byte_seen_q <= 1'b0;
      done_seen_q <= 1'b0;
    end
    else
    begin
      byte_s_q <= {byte_s_q[0], link_byte_tgl_w};
      done_s_q <= {done_s_q[0], link_done_tgl_w};
      byte_seen_q <= byte_s_q[1];
      done_seen_q <= done_s_q[1];
    end
  end

  assign new_byte_w = byte_s_q[1] ^ byte_seen_q;
  assign new_done_w = done_s_q[1] ^ done_seen_q;

  // The engine waits on each acknowledge, so a byte cannot be overwritten unread.
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      ack_tgl_q <= 1'b0;
      shr_q <= 64'h0;
    end
    else if (new_byte_w)
    begin
      ack_tgl_q <= ~ack_tgl_q;
      shr_q <= {shr_q[55:0], link_byte_w};
    end
  end

  // ==========================================================================
  // Header and size checks.
  assign region_base_pointer_w  = shr_q[63:32];
  assign application_code_offset_w  = shr_q[31:0];
  assign start_w = {1'b0, region_base_pointer_w} + {1'b0, application_code_offset_w};
  assign end_w   = {9'h0, start_q} + {1'b0, shr_q[31:0]} + 33'(APP_BYTES);

  assign hdr_bad_w = (region_base_pointer_w == fbl_pkg::ALL_ONES) || (application_code_offset_w == fbl_pkg::ALL_ONES) ||
                     (region_base_pointer_w >= 32'(FLASH_BYTES)) || (start_w >= 33'(FLASH_BYTES));
  assign csz_bad_w = (shr_q[31:0] > fbl_pkg::CFG_MAX_BYTES) ||
                     (end_w > 33'(FLASH_BYTES));
  assign bad_w = (st_q == fbl_pkg::S_HDR_CHK) ? hdr_bad_w : csz_bad_w;

  // ==========================================================================
  // Boot sequencer.
  // A failed region is abandoned at once; the high header is the only retry.
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      st_q <= fbl_pkg::S_WAIT_ADDR;
      rd_addr_q <= 24'h0;
      rd_len_q <= 24'h0;
      req_tgl_q <= 1'b0;
      high_q <= 1'b0;
      start_q <= 24'h0;
      csz_q <= 32'h0;
      cnt_q <= 24'h0;
      dead_battery_o <= 1'b0;
      power_path_sel_o <= 1'b0;
      role_secondary_o <= 1'b0;
    end
    else
    begin
      unique case (st_q)
        fbl_pkg::S_WAIT_ADDR:
        begin
          if (addr_done_w)
            st_q <= fbl_pkg::S_SUPPLY;
        end
        fbl_pkg::S_SUPPLY:
        begin
          if (!main_ok_w && vbus_ok_w)
            st_q <= fbl_pkg::S_DEADBAT;
          else
            st_q <= fbl_pkg::S_ROLE;
        end
        fbl_pkg::S_DEADBAT:
        begin
          dead_battery_o <= 1'b1;
          power_path_sel_o <= bus_pwr_w;
          st_q <= fbl_pkg::S_ROLE;
        end
        fbl_pkg::S_ROLE:
        begin
          // An open strap is the single secondary of a two-device system.
          role_secondary_o <= ~strap_w;
          if (strap_w)
          begin
            rd_addr_q <= fbl_pkg::LOW_HDR_ADDR;
            rd_len_q <= fbl_pkg::HDR_READ_LEN;
            req_tgl_q <= ~req_tgl_q;
            high_q <= 1'b0;
            st_q <= fbl_pkg::S_HDR;
          end
          else
          begin
            cnt_q <= 24'h0;
            st_q <= fbl_pkg::S_UART;
          end
        end
        fbl_pkg::S_HDR:
        begin
          if (new_done_w)
            st_q <= fbl_pkg::S_HDR_CHK;
        end
        fbl_pkg::S_CSZ:
        begin
          if (new_done_w)
            st_q <= fbl_pkg::S_CSZ_CHK;
        end
        fbl_pkg::S_HDR_CHK, fbl_pkg::S_CSZ_CHK:
        begin
          if (bad_w && !high_q)
          begin
            high_q <= 1'b1;
            rd_addr_q <= fbl_pkg::HIGH_HDR_ADDR;
            rd_len_q <= fbl_pkg::HDR_READ_LEN;
            req_tgl_q <= ~req_tgl_q;
            st_q <= fbl_pkg::S_HDR;
          end
          else if (bad_w)
            st_q <= fbl_pkg::S_INVALID;
          else if (st_q == fbl_pkg::S_HDR_CHK)
          begin
            start_q <= start_w[23:0];
            rd_addr_q <= start_w[23:0];
            rd_len_q <= fbl_pkg::CSZ_READ_LEN;
            req_tgl_q <= ~req_tgl_q;
            st_q <= fbl_pkg::S_CSZ;
          end
          else
          begin
            csz_q <= shr_q[31:0];
            rd_addr_q <= start_q + fbl_pkg::CSZ_READ_LEN;
            rd_len_q <= shr_q[23:0] + 24'(APP_BYTES);
            req_tgl_q <= ~req_tgl_q;
            cnt_q <= 24'h0;
            st_q <= fbl_pkg::S_LOAD;
          end
        end
        fbl_pkg::S_LOAD:
        begin
          if (new_byte_w)
            cnt_q <= cnt_q + 24'h1;
          if (new_done_w)
            st_q <= fbl_pkg::S_DONE;
        end
        fbl_pkg::S_UART:
        begin
          if (uart_valid_w)
          begin
            cnt_q <= cnt_q + 24'h1;
            if (cnt_q == 24'(APP_BYTES - 1))
              st_q <= fbl_pkg::S_DONE;
          end
        end
        fbl_pkg::S_DONE, fbl_pkg::S_INVALID:
        begin
          st_q <= st_q;
        end
        default:
        begin
          st_q <= fbl_pkg::S_INVALID;
        end
      endcase
    end
  end

  // ==========================================================================
  // Code stream and outcome.
  // The stream has no back-pressure; the consumer must take one byte per pulse.
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      data_o <= 8'h0;
      data_valid_o <= 1'b0;
      data_is_config_o <= 1'b0;
    end
    else
    begin
      data_valid_o <= (st_q == fbl_pkg::S_LOAD && new_byte_w) ||
                      (st_q == fbl_pkg::S_UART && uart_valid_w);
      if (st_q == fbl_pkg::S_LOAD && new_byte_w)
      begin
        data_o <= link_byte_w; // Taken only while the link holds the byte still.
        data_is_config_o <= ({8'h0, cnt_q} < csz_q);
      end
      else if (st_q == fbl_pkg::S_UART && uart_valid_w)
      begin
        data_o <= uart_byte_w;
        data_is_config_o <= 1'b0;
      end
    end
  end

  // Outcome flags are levels held until the next reset.
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      boot_done_o <= 1'b0;
      loaded_high_o <= 1'b0;
      both_invalid_o <= 1'b0;
      swd_on_sbu_o <= 1'b0;
    end
    else
    begin
      boot_done_o <= (st_q == fbl_pkg::S_DONE);
      loaded_high_o <= (st_q == fbl_pkg::S_DONE) && high_q && !role_secondary_o;
      both_invalid_o <= (st_q == fbl_pkg::S_INVALID);
      swd_on_sbu_o <= (st_q == fbl_pkg::S_INVALID);
    end
  end

  // ==========================================================================
  // Link engine on the SPI reference clock.
  fbl_spi #(
    .HALF(SPI_HALF)
  ) u_spi (
    .clk_i      (spi_clk_i),
    .rst_i      (rst_i),
    .req_tgl_i  (req_tgl_q),
    .addr_i     (rd_addr_q),
    .len_i      (rd_len_q),
    .ack_tgl_i  (ack_tgl_q),
    .miso_i     (flash_miso_i),
    .sck_o      (flash_sck_o),
    .cs_n_o     (flash_select_n_o),
    .mosi_o     (flash_mosi_o),
    .byte_o     (link_byte_w),
    .byte_tgl_o (link_byte_tgl_w),
    .done_tgl_o (link_done_tgl_w)
  );

  // Download receiver for the secondary role.
  fbl_uart_rx #(
    .DIV(BAUD_DIV)
  ) u_uart (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .rx_i    (uart_rx_i),
    .byte_o  (uart_byte_w),
    .valid_o (uart_valid_w)
  );

endmodule // fbl_top
`default_nettype wire

/* sim/fbl_flash_model.sv */
`timescale 1ns/1ns
`default_nettype none
// ==========
// Serial flash partner: read command only, erased cells read as ones.
module fbl_flash_model (
  input  wire logic sck_i,
  input  wire logic cs_n_i,
  input  wire logic mosi_i,
  output logic      miso_o
);
  logic [7:0]  mem [int]; // Sparse array covers the full 24-bit space.
  logic [31:0] sh;
  logic [31:0] cmd;
  int          n = 0;
  int          k;
  initial miso_o = 1'b0;
  // Erase works on whole 4 kB sectors, the unit the two headers rely on.
  task automatic erase_4k(input int a);
    for (int i = 0; i < 4096; i++)
      if (mem.exists((a & ~4095) + i))
        mem.delete((a & ~4095) + i);
  endtask
  // Take MOSI on the rising edge; opcode and address are latched after 32 bits.
  always @(posedge sck_i)
  begin
    sh = {sh[30:0], mosi_i};
    n = cs_n_i ? 0 : n + 1;
    if (n == 32)
      cmd = sh;
  end
  // Data leaves on the falling edge; an undriven line shows its last level inverted.
  always @(negedge sck_i or negedge cs_n_i or posedge cs_n_i)
  begin
    k = n - 32;
    if (cs_n_i)
      n = 0;
    if (cs_n_i || n < 32 || cmd[31:24] != 8'h03)
      miso_o = ~miso_o;
    else
      miso_o = mem.exists(cmd[23:0] + k / 8) ? mem[cmd[23:0] + k / 8][7 - k % 8] : 1'b1;
  end
endmodule // fbl_flash_model
`default_nettype wire

/* sim/fbl_top_sva.sv */
`timescale 1ns/1ns
`default_nettype none
// ==========
// Port checker for the boot loader.
module fbl_top_sva #(
  parameter int unsigned SPI_HALF = fbl_pkg::SPI_HALF_CYC
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic spi_clk_i,
  input wire logic flash_sck_o,
  input wire logic flash_select_n_o,
  input wire logic flash_mosi_o,
  input wire logic role_secondary_o,
  input wire logic boot_done_o,
  input wire logic loaded_high_o,
  input wire logic both_invalid_o,
  input wire logic swd_on_sbu_o
);
  logic       sck_q;
  logic [3:0] half_q;
  logic [3:0] rise_q;
  // Link cycles since SCK last moved; saturates so long idles cannot wrap.
  always_ff @(posedge spi_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      sck_q  <= 1'b0;
      half_q <= 4'h0;
    end
    else
    begin
      sck_q <= flash_sck_o;
      if (flash_sck_o != sck_q)
        half_q <= 4'h0;
      else if (half_q != 4'hf)
        half_q <= half_q + 4'h1;
    end
  end
  // Rising SCK edges within a frame, held once the opcode has passed.
  always_ff @(posedge spi_clk_i or posedge rst_i)
  begin
    if (rst_i)
      rise_q <= 4'h0;
    else if (flash_select_n_o)
      rise_q <= 4'h0;
    else if (flash_sck_o && !sck_q && rise_q != 4'h8)
      rise_q <= rise_q + 4'h1;
  end
  idle_sck_a: assert property (@(posedge spi_clk_i) disable iff (rst_i) flash_select_n_o |-> !flash_sck_o)
    else $error("SCK moved while deselected.");
  opcode_a: assert property (@(posedge spi_clk_i) disable iff (rst_i)
    (!flash_select_n_o && flash_sck_o && !sck_q && rise_q < 4'h8) |-> flash_mosi_o == (rise_q >= 4'h6))
    else $error("Read opcode bit wrong.");
  sck_half_a: assert property (@(posedge spi_clk_i) disable iff (rst_i) (flash_sck_o != sck_q) |-> half_q >= SPI_HALF - 1)
    else $error("SCK half period too short.");
  swd_route_a: assert property (@(posedge clk_i) disable iff (rst_i) both_invalid_o |-> ##[0:2] swd_on_sbu_o)
    else $error("Debug port not routed.");
  no_start_a: assert property (@(posedge clk_i) disable iff (rst_i) both_invalid_o |-> !boot_done_o)
    else $error("Code started from bad flash.");
  sec_flash_a: assert property (@(posedge clk_i) disable iff (rst_i) role_secondary_o |-> flash_select_n_o)
    else $error("Secondary touched the flash.");
  high_done_a: assert property (@(posedge clk_i) disable iff (rst_i) loaded_high_o |-> boot_done_o && !role_secondary_o)
    else $error("High region flag without load.");
  done_hold_a: assert property (@(posedge clk_i) disable iff (rst_i) boot_done_o |=> boot_done_o)
    else $error("Boot done dropped.");
  // Main outcomes that the bench must reach.
  cover property (@(posedge clk_i) disable iff (rst_i) boot_done_o && loaded_high_o);
  cover property (@(posedge clk_i) disable iff (rst_i) boot_done_o && role_secondary_o);
  cover property (@(posedge clk_i) disable iff (rst_i) both_invalid_o);
endmodule // fbl_top_sva
bind fbl_top fbl_top_sva #(.SPI_HALF(SPI_HALF)) u_sva (.clk_i, .rst_i, .spi_clk_i, .flash_sck_o, .flash_select_n_o,
  .flash_mosi_o, .role_secondary_o, .boot_done_o, .loaded_high_o, .both_invalid_o, .swd_on_sbu_o);
`default_nettype wire

/* sim/tb_top.sv */
`timescale 1ns/1ns
`default_nettype none
// ==========
// Bench: flash boot, fallback, bad flash and UART download.
module tb_top;
  localparam int unsigned APP = 16;
  localparam int unsigned DIV = 8;
  logic       clk_i = 1'b0;
  logic       spi_clk_i = 1'b0;
  logic       rst_i = 1'b1;
  logic       addr_done = 1'b0;
  logic       main_ok = 1'b1;
  logic       bps = 1'b0;
  logic       strap = 1'b1;
  logic       rx = 1'b1;
  logic       vbus = 1'b1;
  logic       sck, cs_n, mosi, miso, dead, path, sec, dv, dcfg, done, high, binv, swd;
  logic [7:0] data;
  logic [8:0] got [$];
  logic [8:0] exp [$];
  int         err_count = 0;
  int         cmp_count = 0;
  // Core clock and a link clock unrelated in phase.
  always #25 clk_i = ~clk_i;
  always #6 spi_clk_i = ~spi_clk_i;
  fbl_top #(.APP_BYTES(APP), .BAUD_DIV(DIV)) dut (.clk_i(clk_i), .rst_i(rst_i), .spi_clk_i(spi_clk_i),
    .addr_setup_done_i(addr_done), .main_supply_input_i(main_ok), .vbus_valid_i(vbus),
    .bus_power_select_pin_i(bps), .addr_strap_grounded_i(strap), .uart_rx_i(rx), .flash_miso_i(miso),
    .flash_sck_o(sck), .flash_select_n_o(cs_n), .flash_mosi_o(mosi), .dead_battery_o(dead),
    .power_path_sel_o(path), .role_secondary_o(sec), .data_o(data), .data_valid_o(dv),
    .data_is_config_o(dcfg), .boot_done_o(done), .loaded_high_o(high), .both_invalid_o(binv),
    .swd_on_sbu_o(swd));
  fbl_flash_model flash (.sck_i(sck), .cs_n_i(cs_n), .mosi_i(mosi), .miso_o(miso));
  // Record each streamed byte with its configuration flag.
  always @(negedge clk_i)
    if (dv === 1'b1)
      got.push_back({dcfg, data});
  task automatic chk(input logic ok, input string msg);
    cmp_count++;
    if (ok !== 1'b1)
    begin
      err_count++;
      $display("ERROR %0t %s", $time, msg);
    end
  endtask
  function automatic logic [31:0] fw_start(input logic [31:0] p, input logic [31:0] o);
    return p + o;
  endfunction
  task automatic put32(input int a, input logic [31:0] v);
    for (int i = 0; i < 4; i++)
      flash.mem[a + i] = v[31 - 8 * i -: 8];
  endtask
  // Image: size word, then config bytes, then application bytes.
  task automatic img(input logic [31:0] a, input logic [31:0] cs);
    logic [7:0] b;
    put32(a, cs);
    exp.delete();
    for (int i = 0; i < cs + APP; i++)
    begin
      b = 8'($urandom);
      flash.mem[a + 4 + i] = b;
      exp.push_back({i < cs, b});
    end
  endtask
  task automatic boot(input logic m, input logic s);
    got.delete();
    rst_i = 1'b1;
    addr_done = 1'b0;
    main_ok = m;
    bps = 1'($urandom);
    strap = !s;
    repeat (10) @(negedge clk_i);
    rst_i = 1'b0;
    repeat (3) @(negedge clk_i);
    addr_done = 1'b1;
  endtask
  task automatic wait_end();
    for (int i = 0; i < 20000 && !((done === 1'b1 && got.size() >= exp.size()) || (binv === 1'b1 && swd === 1'b1)); i++)
      @(negedge clk_i);
  endtask
  // 8N1, least significant bit first, idle high.
  task automatic uart_tx(input logic [7:0] b);
    for (int j = 0; j < 10; j++)
    begin
      rx = (j == 0) ? 1'b0 : (j == 9) ? 1'b1 : b[j - 1];
      repeat (DIV) @(negedge clk_i);
    end
  endtask
  task automatic end_test(input string name);
    int base;
    base = got.size() - exp.size();
    chk(base >= 0, "stream too short");
    for (int i = 0; i < exp.size() && base >= 0; i++)
      chk(got[base + i] === exp[i], "stream byte");
    $display("test %s done", name);
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // Hang guard, far beyond the few thousand cycles the tests need.
  initial
  begin
    repeat (60000) @(posedge clk_i);
    err_count++;
    close_out();
  end
  initial
  begin
    logic [31:0] p;
    logic [31:0] o;
    logic [7:0]  b;
    void'($urandom(32'h8e1e));
    // Good low region on a dead-battery boot.
    p = 32'h00002000 + (($urandom % 16) << 12);
    o = $urandom % 256;
    put32(0, p);
    put32(4, o);
    img(fw_start(p, o), $urandom % 33);
    boot(1'b0, 1'b0);
    wait_end();
    chk(done === 1'b1 && high === 1'b0, "low load");
    chk(dead === 1'b1 && path === bps, "dead battery");
    end_test("low");
    // Low size word one past the limit, so the high region loads.
    flash.mem.delete();
    put32(0, 32'h00003000);
    put32(4, 32'h0);
    put32(32'h3000, 32'h00001001);
    p = 32'h00040000;
    o = $urandom % 4096;
    put32(32'h1000, p);
    put32(32'h1004, o);
    img(fw_start(p, o), $urandom % 33);
    boot(1'b1, 1'b0);
    wait_end();
    chk(done === 1'b1 && high === 1'b1 && dead === 1'b0, "high fallback");
    end_test("high");
    // Erased header sectors give all-ones pointers; neither supply is valid.
    flash.erase_4k(0);
    flash.erase_4k(32'h1000);
    exp.delete();
    vbus = 1'b0;
    boot(1'b0, 1'b0);
    wait_end();
    chk(binv === 1'b1 && swd === 1'b1 && done === 1'b0 && cs_n === 1'b1, "invalid flow");
    chk(dead === 1'b0, "dead battery without bus voltage");
    end_test("invalid");
    // Secondary takes its code over UART.
    vbus = 1'b1;
    exp.delete();
    boot(1'b1, 1'b1);
    for (int i = 0; i < 50 && sec !== 1'b1; i++)
      @(negedge clk_i);
    for (int i = 0; i < APP; i++)
    begin
      b = 8'($urandom);
      exp.push_back({1'b0, b});
      uart_tx(b);
    end
    wait_end();
    chk(sec === 1'b1 && done === 1'b1 && high === 1'b0, "uart load");
    end_test("uart");
    close_out();
  end
endmodule // tb_top
`default_nettype wire
